//--- logic/cal_sync_pkg.sv
package cal_sync_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int RAW_W = 24;          // Raw converter result width
  localparam int ZS_MAG_W = 22;       // Channel offset magnitude width
  localparam int CH_NUM = 4;          // Channel count
  localparam int CH_W = 2;            // Channel index width
  localparam int CT_W = 16;           // Conversion time count width

  // ****************************************************************
  // Register offsets (8-bit address)
  // ****************************************************************
  localparam logic [7:0] ADDR_MODE = 8'h00;     // Mode and channel select
  localparam logic [7:0] ADDR_PORT = 8'h04;     // Port pins and gate enable
  localparam logic [7:0] ADDR_ADC_STAT = 8'h08; // Ready bits per channel
  localparam logic [7:0] ADDR_ADC_ZS = 8'h0C;   // ADC zero-scale
  localparam logic [7:0] ADDR_ADC_FS = 8'h10;   // ADC full-scale
  localparam logic [7:0] ADDR_RAW = 8'h14;      // Raw result (test input)
  localparam logic [7:0] ADDR_CH_BASE = 8'h40;  // Per channel block
  localparam logic [7:0] ADDR_CH_STRIDE = 8'h10; // Bytes per channel
  localparam logic [3:0] CH_DATA = 4'h0;        // Channel data
  localparam logic [3:0] CH_STAT = 4'h4;        // Channel status
  localparam logic [3:0] CH_ZS = 4'h8;          // Channel zero-scale
  localparam logic [3:0] CH_FS = 4'hC;          // Channel full-scale
  localparam logic [3:0] CH_CT = 4'h0;          // Conv time (offset in 0x80)
  localparam logic [7:0] ADDR_CT_BASE = 8'h80;  // Conversion time block

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MODE_LSB = 0;        // Mode code bits [2:0]
  localparam int MODE_CH_LSB = 4;     // Channel select bits [5:4]
  localparam int MODE_BIP = 8;        // Bipolar range bit
  localparam int PORT_P0_OUT = 0;     // Pin zero output value
  localparam int PORT_P1_OUT = 1;     // Pin one output value
  localparam int PORT_P0_OE = 2;      // Pin zero drive enable
  localparam int PORT_P1_OE = 3;      // Pin one drive enable
  localparam int PORT_GATE = 4;       // Start-gate enable
  localparam int PORT_P0_IN = 8;      // Pin zero level (read)
  localparam int PORT_P1_IN = 9;      // Pin one level (read)
  localparam int CST_RDY = 0;         // Channel status ready
  localparam int CST_REFERENCE_MISSING_FLAG = 1;       // Channel status ref missing

  // ****************************************************************
  // Scaling constants
  // ****************************************************************
  localparam int UNI_DIV_SH = 21;     // Divide by 200000h
  localparam int BIP_DIV1_SH = 18;    // Divide by 40000h
  localparam int BIP_DIV2_SH = 17;    // Divide by 20000h
  localparam logic signed [47:0] BIP_MID = 48'sh80000; // Plus 80000h

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [23:0] ADC_ZS_RST = 24'h000000; // ADC zero-scale
  localparam logic [23:0] ADC_FS_RST = 24'h200000; // ADC full-scale
  localparam logic [23:0] CH_FS_RST = 24'h200000;  // Channel full-scale
  localparam logic [15:0] CT_RST = 16'h0100;       // Conversion cycles

  // ****************************************************************
  // Reference detect, 0.5 V in millivolts
  // ****************************************************************
  localparam logic [15:0] REFERENCE_MISSING_FLAG_MV = 16'h01F4;

  // Mode codes
  typedef enum logic [2:0] {
    MODE_IDLE = 3'h0,
    MODE_CONT = 3'h1,
    MODE_SINGLE = 3'h2,
    MODE_PDOWN = 3'h3,
    MODE_ZS_SELF = 3'h4,
    MODE_FS_SELF = 3'h5,
    MODE_ZS_SYS = 3'h6,
    MODE_FS_SYS = 3'h7
  } mode_t;

endpackage

//--- logic/cal_scaler.sv
// ****************************************************************
// Two-stage calibration scaler, one cycle latency
// ****************************************************************
module cal_scaler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Operands
  input wire logic [23:0] raw,
  input wire logic bipolar,
  input wire logic [23:0] adc_zs,
  input wire logic [23:0] adc_fs,
  input wire logic [23:0] ch_zs,
  input wire logic [23:0] ch_fs,
  // Result
  output logic [23:0] data
);

  // Wide signed intermediates
  logic signed [63:0] s1;
  logic signed [63:0] s2;
  logic signed [63:0] zs_ch;
  logic [23:0] data_d;

  // Sign-magnitude to signed
  function automatic logic signed [63:0] sm_to_s(input logic [23:0] v);
    logic signed [63:0] m;
    m = 64'(v[cal_sync_pkg::ZS_MAG_W-1:0]);
    sm_to_s = v[cal_sync_pkg::ZS_MAG_W] ? -m : m;
  endfunction

  // Arithmetic, ADC stage then channel stage
  always_comb begin
    zs_ch = sm_to_s(ch_zs);
    s1 = (64'(raw) - 64'(adc_zs)) * 64'(adc_fs);
    if (bipolar) begin
      s1 = (s1 >>> cal_sync_pkg::BIP_DIV1_SH) + 64'(cal_sync_pkg::BIP_MID);
      // Signed operand keeps the shift arithmetic for negative products
      s2 = ((s1 - zs_ch) * $signed(64'(ch_fs)))
           >>> cal_sync_pkg::BIP_DIV2_SH;
    end else begin
      s1 = s1 >>> cal_sync_pkg::UNI_DIV_SH;
      s2 = ((s1 - zs_ch) * $signed(64'(ch_fs)))
           >>> cal_sync_pkg::UNI_DIV_SH;
    end
    // Saturate to data width
    if (s2 < 0) begin
      data_d = 24'h000000;
    end else if (s2 > 64'sh FFFFFF) begin
      data_d = 24'hFFFFFF;
    end else begin
      data_d = s2[23:0];
    end
  end

  // Register the result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data <= 24'h000000;
    end else begin
      data <= data_d;
    end
  end

endmodule // cal_scaler

//--- logic/cal_sync_ctrl.sv
// Decided for this implementation: the strobed register port and the register offsets.
module cal_sync_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Converter side
  input wire logic [23:0] raw_result,
  input wire logic [15:0] ref_mv,
  output logic inputs_shorted,
  output logic busy,
  // Port pins
  input wire logic port_pin_zero_in,
  output logic port_pin_zero_out,
  output logic port_pin_zero_oe,
  input wire logic port_pin_one_in,
  output logic port_pin_one_out,
  output logic port_pin_one_oe,
  // Ready output
  output logic ready_n
);

  // ****************************************************************
  // Reset synchroniser
  // ****************************************************************
  logic rst_s1_q;
  logic rst_n;

  // Two-stage release
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {S_IDLE, S_PEND, S_RUN, S_SCALE, S_DONE} st_t;

  st_t st_q, st_d;
  logic [2:0] mode_q, mode_d;          // Active mode code
  logic [1:0] ch_q, ch_d;              // Selected channel
  logic bip_q, bip_d;                  // Bipolar range
  logic [4:0] port_q, port_d;          // Port control bits
  logic [3:0] adc_rdy_q, adc_rdy_d;    // ADC status ready bits
  logic [23:0] adc_zs_q, adc_zs_d;     // ADC zero-scale
  logic [23:0] adc_fs_q, adc_fs_d;     // ADC full-scale
  logic [23:0] ch_data_q [4];          // Channel data
  logic [23:0] ch_data_d [4];
  logic [1:0] ch_st_q [4];             // Channel status bits
  logic [1:0] ch_st_d [4];
  logic [23:0] ch_zs_q [4];            // Channel zero-scale
  logic [23:0] ch_zs_d [4];
  logic [23:0] ch_fs_q [4];            // Channel full-scale
  logic [23:0] ch_fs_d [4];
  logic [15:0] ct_q [4];               // Conversion time per channel
  logic [15:0] ct_d [4];
  logic [15:0] cnt_q, cnt_d;           // Run counter
  logic p1_prev_q, p1_prev_d;          // Gate pin history
  logic [31:0] rdata_d;
  logic ready_n_d, p1o_d;
  logic [23:0] scaled;
  logic gate_en, gate_rise, is_cal, is_conv, mode_wr;
  logic [2:0] wmode;
  logic [1:0] ach;

  // Channel of an address in a block
  function automatic logic [1:0] ch_of(input logic [7:0] a);
    ch_of = a[5:4];
  endfunction

  // Scaler, fed from the selected channel
  cal_scaler u_scaler (
    .clk(core_clk),
    .rst_n(rst_n),
    .raw(raw_result),
    .bipolar(bip_q),
    .adc_zs(adc_zs_q),
    .adc_fs(adc_fs_q),
    .ch_zs(ch_zs_q[ch_q]),
    .ch_fs(ch_fs_q[ch_q]),
    .data(scaled)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    ch_d = ch_q;
    bip_d = bip_q;
    port_d = port_q;
    adc_rdy_d = adc_rdy_q;
    adc_zs_d = adc_zs_q;
    adc_fs_d = adc_fs_q;
    ch_data_d = ch_data_q;
    ch_st_d = ch_st_q;
    ch_zs_d = ch_zs_q;
    ch_fs_d = ch_fs_q;
    ct_d = ct_q;
    cnt_d = cnt_q;
    p1o_d = port_q[cal_sync_pkg::PORT_P1_OUT];
    ready_n_d = ready_n;
    p1_prev_d = port_pin_one_in;
    gate_en = port_q[cal_sync_pkg::PORT_GATE];
    gate_rise = port_pin_one_in && !p1_prev_q;
    is_cal = mode_q[2];
    is_conv = (mode_q == cal_sync_pkg::MODE_CONT)
           || (mode_q == cal_sync_pkg::MODE_SINGLE);
    wmode = wdata[cal_sync_pkg::MODE_LSB +: 3];
    mode_wr = wr && addr == cal_sync_pkg::ADDR_MODE;
    ach = ch_of(addr);

    // Register writes
    if (wr) begin
      if (addr == cal_sync_pkg::ADDR_PORT) begin
        port_d = wdata[4:0];
        p1o_d = wdata[cal_sync_pkg::PORT_P1_OUT];
      end
      if (st_q == S_IDLE) begin
        if (addr == cal_sync_pkg::ADDR_ADC_ZS) begin
          adc_zs_d = wdata[23:0];
        end
        if (addr == cal_sync_pkg::ADDR_ADC_FS) begin
          adc_fs_d = wdata[23:0];
        end
        // Channel calibration only in idle
        if (addr[7:6] == 2'b01 && addr[3:0] == cal_sync_pkg::CH_ZS) begin
          ch_zs_d[ach] = wdata[23:0];
        end
        if (addr[7:6] == 2'b01 && addr[3:0] == cal_sync_pkg::CH_FS) begin
          ch_fs_d[ach] = wdata[23:0];
        end
        if (addr[7:6] == 2'b10 && addr[3:0] == cal_sync_pkg::CH_CT) begin
          ct_d[ach] = wdata[15:0];
        end
      end
    end

    // Sequencer
    case (st_q)
      S_IDLE: begin
        if (mode_wr) begin
          mode_d = wmode;
          ch_d = wdata[cal_sync_pkg::MODE_CH_LSB +: 2];
          bip_d = wdata[cal_sync_pkg::MODE_BIP];
          if (wmode != cal_sync_pkg::MODE_IDLE
              && wmode != cal_sync_pkg::MODE_PDOWN) begin
            st_d = S_PEND;
          end
        end
      end
      S_PEND: begin
        // Hold request until gate opens
        if (!gate_en || gate_rise) begin
          st_d = S_RUN;
          cnt_d = ct_q[ch_q];
        end
        if (mode_wr && wmode == cal_sync_pkg::MODE_IDLE) begin
          st_d = S_IDLE;
          mode_d = wmode;
        end
      end
      S_RUN: begin
        if (is_conv) begin
          ready_n_d = 1'b1;
          if (ref_mv < cal_sync_pkg::REFERENCE_MISSING_FLAG_MV) begin
            ch_st_d[ch_q][cal_sync_pkg::CST_REFERENCE_MISSING_FLAG] = 1'b1;
          end
        end
        if (gate_en && !port_pin_one_in && is_conv) begin
          st_d = S_PEND;
        end else if (cnt_q <= 16'h0001) begin
          st_d = is_cal ? S_DONE : S_SCALE;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      S_SCALE: begin
        st_d = S_DONE; // Scaler latency
      end
      S_DONE: begin
        if (is_cal) begin
          // Calibration result capture
          case (mode_q)
            cal_sync_pkg::MODE_ZS_SELF: adc_zs_d = raw_result;
            cal_sync_pkg::MODE_FS_SELF: adc_fs_d = raw_result;
            cal_sync_pkg::MODE_ZS_SYS: ch_zs_d[ch_q] = raw_result;
            cal_sync_pkg::MODE_FS_SYS: ch_fs_d[ch_q] = raw_result;
            default: ;
          endcase
          adc_rdy_d = 4'hF;
          p1o_d = 1'b0;
          // Keep pin one low after the end, not just one cycle
          port_d[cal_sync_pkg::PORT_P1_OUT] = 1'b0;
          mode_d = cal_sync_pkg::MODE_IDLE;
          st_d = S_IDLE;
        end else begin
          ch_data_d[ch_q] = scaled;
          adc_rdy_d[ch_q] = 1'b1;
          ch_st_d[ch_q][cal_sync_pkg::CST_RDY] = 1'b1;
          ready_n_d = 1'b0;
          if (mode_q == cal_sync_pkg::MODE_CONT) begin
            st_d = S_RUN;
            cnt_d = ct_q[ch_q];
          end else begin
            mode_d = cal_sync_pkg::MODE_IDLE;
            st_d = S_IDLE;
          end
        end
      end
      default: st_d = S_IDLE;
    endcase

    // Data read clears ready, conversion-end set wins if same cycle
    if (rd && addr[7:6] == 2'b01 && addr[3:0] == cal_sync_pkg::CH_DATA
        && !(st_q == S_DONE && !is_cal && ach == ch_q)) begin
      adc_rdy_d[ach] = 1'b0;
      ch_st_d[ach][cal_sync_pkg::CST_RDY] = 1'b0;
    end

    // Read mux
    rdata_d = 32'h00000000;
    if (rd) begin
      if (addr == cal_sync_pkg::ADDR_MODE) begin
        rdata_d = {23'h000000, bip_q, 2'h0, ch_q, 1'b0, mode_q};
      end else if (addr == cal_sync_pkg::ADDR_PORT) begin
        rdata_d = {22'h000000, port_pin_one_in, port_pin_zero_in,
                   3'h0, port_q};
      end else if (addr == cal_sync_pkg::ADDR_ADC_STAT) begin
        rdata_d = {28'h0000000, adc_rdy_q};
      end else if (addr == cal_sync_pkg::ADDR_ADC_ZS) begin
        rdata_d = {8'h00, adc_zs_q};
      end else if (addr == cal_sync_pkg::ADDR_ADC_FS) begin
        rdata_d = {8'h00, adc_fs_q};
      end else if (addr == cal_sync_pkg::ADDR_RAW) begin
        rdata_d = {8'h00, raw_result};
      end else if (addr[7:6] == 2'b01) begin
        case (addr[3:0])
          cal_sync_pkg::CH_DATA: rdata_d = {8'h00, ch_data_q[ach]};
          cal_sync_pkg::CH_STAT: rdata_d = {30'h00000000, ch_st_q[ach]};
          cal_sync_pkg::CH_ZS: rdata_d = {8'h00, ch_zs_q[ach]};
          cal_sync_pkg::CH_FS: rdata_d = {8'h00, ch_fs_q[ach]};
          default: rdata_d = 32'h00000000;
        endcase
      end else if (addr[7:6] == 2'b10 && addr[3:0] == cal_sync_pkg::CH_CT) begin
        rdata_d = {16'h0000, ct_q[ach]};
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      mode_q <= cal_sync_pkg::MODE_IDLE;
      ch_q <= 2'h0;
      bip_q <= 1'b0;
      port_q <= 5'h00;
      adc_rdy_q <= 4'h0;
      adc_zs_q <= cal_sync_pkg::ADC_ZS_RST;
      adc_fs_q <= cal_sync_pkg::ADC_FS_RST;
      for (int i = 0; i < cal_sync_pkg::CH_NUM; i++) begin
        ch_data_q[i] <= 24'h000000;
        ch_st_q[i] <= 2'h0;
        ch_zs_q[i] <= 24'h000000;
        ch_fs_q[i] <= cal_sync_pkg::CH_FS_RST;
        ct_q[i] <= cal_sync_pkg::CT_RST;
      end
      cnt_q <= 16'h0000;
      p1_prev_q <= 1'b0;
      rdata <= 32'h00000000;
      ready_n <= 1'b1;
      port_pin_one_out <= 1'b0;
      port_pin_zero_out <= 1'b0;
      port_pin_zero_oe <= 1'b0;
      port_pin_one_oe <= 1'b0;
      inputs_shorted <= 1'b0;
      busy <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      ch_q <= ch_d;
      bip_q <= bip_d;
      port_q <= port_d;
      adc_rdy_q <= adc_rdy_d;
      adc_zs_q <= adc_zs_d;
      adc_fs_q <= adc_fs_d;
      ch_data_q <= ch_data_d;
      ch_st_q <= ch_st_d;
      ch_zs_q <= ch_zs_d;
      ch_fs_q <= ch_fs_d;
      ct_q <= ct_d;
      cnt_q <= cnt_d;
      p1_prev_q <= p1_prev_d;
      rdata <= rdata_d;
      ready_n <= ready_n_d;
      port_pin_one_out <= p1o_d;
      port_pin_zero_out <= port_d[cal_sync_pkg::PORT_P0_OUT];
      port_pin_zero_oe <= port_d[cal_sync_pkg::PORT_P0_OE];
      // Pin one drives only when its enable bit is set, in every mode; its output value is low after calibration
      port_pin_one_oe <= port_d[cal_sync_pkg::PORT_P1_OE];
      inputs_shorted <= (st_d == S_RUN)
                     && (mode_d == cal_sync_pkg::MODE_ZS_SELF);
      busy <= (st_d != S_IDLE);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_gate_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_PEND && gate_en && !port_pin_one_in) |=> st_q != S_RUN)
    else $error("Run started while gate low");
  a_gate_edge_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_PEND && gate_en && gate_rise && !mode_wr) |=> st_q == S_RUN)
    else $error("Rising gate edge did not start");
  a_cal_end_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_DONE && is_cal) |=> (adc_rdy_q == 4'hF && st_q == S_IDLE
    && !port_pin_one_out && mode_q == cal_sync_pkg::MODE_IDLE))
    else $error("Calibration end effects missing");
  a_cal_length: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_RUN && cnt_q == 16'h0002 && is_cal
     && !(gate_en && !port_pin_one_in)) |=> ##1 st_q == S_DONE)
    else $error("Calibration length wrong");
  a_conv_ready: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_DONE && !is_cal) |=> (!ready_n && adc_rdy_q[$past(ch_q)]
    && ch_data_q[$past(ch_q)] == $past(scaled)))
    else $error("Conversion end effects missing");
  a_reference_missing_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_RUN && is_conv && ref_mv < cal_sync_pkg::REFERENCE_MISSING_FLAG_MV)
    |=> ch_st_q[$past(ch_q)][cal_sync_pkg::CST_REFERENCE_MISSING_FLAG])
    else $error("Missing reference not flagged");
  a_idle_cal_wr: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_RUN && !is_cal) |=> $stable(ch_zs_q[ch_q]))
    else $error("Channel offset changed while busy");
  a_pend_held: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_PEND && gate_en && !gate_rise && !mode_wr)
    |=> st_q == S_PEND)
    else $error("Pending start lost");
  a_short_zs: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == S_RUN && mode_q == cal_sync_pkg::MODE_ZS_SELF
     && $past(st_q) == S_RUN) |-> inputs_shorted)
    else $error("Inputs not shorted in self-cal");
  c_cal_done: cover property (@(posedge core_clk) disable iff (!rst_n)
    st_q == S_DONE && is_cal);
  c_conv_done: cover property (@(posedge core_clk) disable iff (!rst_n)
    st_q == S_DONE && !is_cal);
  c_gated_start: cover property (@(posedge core_clk) disable iff (!rst_n)
    st_q == S_PEND && gate_en ##1 st_q == S_RUN);

endmodule // cal_sync_ctrl

//--- verif/host_pins.sv
// ****************************
// Host side of the port pins
// ****************************
module host_pins (
  // Design drive
  input wire logic [1:0] dev_out,
  input wire logic [1:0] dev_oe,
  // Host drive
  input wire logic [1:0] host_out,
  input wire logic [1:0] host_oe,
  // Wire levels
  output logic [1:0] level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic float_q = 1'b0; // Undriven wire pattern
  // Floating wire never holds a stale level
  always #10 float_q = ~float_q;
  // Resolve each pin from both drivers
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (dev_oe[i]) level[i] = dev_out[i];
      else if (host_oe[i]) level[i] = host_out[i];
      else level[i] = float_q;
    end
  end
endmodule // host_pins

//--- verif/adc_calibration_sync_control_tb.sv
module adc_calibration_sync_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [23:0] raw_result = 24'h0, raw;
  logic [15:0] ref_mv = 16'h09C4;
  logic inputs_shorted, busy, ready_n;
  logic [1:0] dout, doe, lvl, host_out = 2'h1, host_oe = 2'h3;
  logic [7:0] tbl [4] = '{8'h0C, 8'h10, 8'h48, 8'h4C}; // Cal targets
  int fail_count = 0, checked = 0, n, s;
  always #10 core_clk = ~core_clk;
  cal_sync_ctrl cal_sync_ctrl_i (.core_clk(core_clk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .raw_result(raw_result), .ref_mv(ref_mv),
    .inputs_shorted(inputs_shorted), .busy(busy),
    .port_pin_zero_in(lvl[0]), .port_pin_zero_out(dout[0]),
    .port_pin_zero_oe(doe[0]), .port_pin_one_in(lvl[1]),
    .port_pin_one_out(dout[1]), .port_pin_one_oe(doe[1]),
    .ready_n(ready_n));
  host_pins host_pins_i (.dev_out(dout), .dev_oe(doe),
    .host_out(host_out), .host_oe(host_oe), .level(lvl));
  // Reference scaling, integer arithmetic
  function automatic logic [23:0] scale(longint r, bit b, longint az,
      longint af, logic [23:0] cz, longint cf);
    longint z, t;
    z = cz[22] ? -longint'(cz[21:0]) : longint'(cz[21:0]);
    if (b) t = ((r - az) * af / 64'h40000 + 64'h80000 - z) * cf / 64'h20000;
    else t = ((r - az) * af / 64'h200000 - z) * cf / 64'h200000;
    if (t < 0) t = 0;
    if (t > 64'hFFFFFF) t = 64'hFFFFFF;
    return t[23:0];
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // Bounded wait for idle, n counts busy cycles
  task wait_idle;
    #1;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk({31'h0, busy}, 32'h0);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    fail_count++;
    summarize();
  end
  initial begin
    s = $urandom(4);
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({31'h0, ready_n}, 32'h1);
    rchk(cal_sync_pkg::ADDR_ADC_FS, 32'h200000);
    rchk(8'hFC, 32'h0);
    $display("test reset done");
    // Unipolar on channel zero
    raw = 24'($urandom);
    raw_result <= raw;
    wr_reg(8'h48, 32'h100);
    wr_reg(cal_sync_pkg::ADDR_MODE, 32'h002);
    wait_idle();
    chk({31'h0, ready_n}, 32'h0);
    rchk(cal_sync_pkg::ADDR_ADC_STAT, 32'h1);
    rchk(8'h44, 32'h1);
    rchk(8'h40, scale(raw, 0, 0, 64'h200000, 24'h100, 64'h200000));
    $display("test unipolar done");
    // Bipolar on channel one, reference missing
    raw = 24'($urandom) & 24'h00FFFF;
    raw_result <= raw;
    ref_mv <= 16'h0064;
    wr_reg(8'h58, 32'h400200);
    wr_reg(8'h5C, 32'h020000);
    wr_reg(cal_sync_pkg::ADDR_MODE, 32'h112);
    wait_idle();
    rchk(8'h54, 32'h3);
    rchk(8'h50, scale(raw, 1, 0, 64'h200000, 24'h400200, 64'h20000));
    ref_mv <= 16'h09C4;
    $display("test bipolar done");
    // Gated start held pending
    raw = 24'($urandom);
    raw_result <= raw;
    host_out[1] <= 1'b0;
    wr_reg(cal_sync_pkg::ADDR_PORT, 32'h10);
    wr_reg(cal_sync_pkg::ADDR_MODE, 32'h002);
    wr_reg(8'h48, 32'h55);
    repeat (300) @(posedge core_clk);
    chk({31'h0, busy}, 32'h1);
    rchk(cal_sync_pkg::ADDR_ADC_STAT, 32'h0);
    host_out[1] <= 1'b1;
    wait_idle();
    rchk(8'h40, scale(raw, 0, 0, 64'h200000, 24'h100, 64'h200000));
    rchk(8'h48, 32'h100);
    // Continuous start blocked, then aborted
    host_out <= 2'h1;
    wr_reg(cal_sync_pkg::ADDR_MODE, 32'h001);
    repeat (20) @(posedge core_clk);
    chk({31'h0, busy}, 32'h1);
    rchk(cal_sync_pkg::ADDR_PORT, 32'h110);
    wr_reg(cal_sync_pkg::ADDR_MODE, 32'h000);
    repeat (3) @(posedge core_clk);
    chk({31'h0, busy}, 32'h0);
    $display("test gate done");
    // Self cals first, then channel zero before full scale
    // ADC registers change only through self-cal here
    for (int m = 4; m < 8; m++) begin
      raw = 24'($urandom);
      raw_result <= raw;
      wr_reg(cal_sync_pkg::ADDR_PORT, 32'h0A);
      wr_reg(cal_sync_pkg::ADDR_MODE, 32'(m));
      repeat (3) @(posedge core_clk);
      chk({31'h0, inputs_shorted}, 32'(m == 4));
      wait_idle();
      chk(32'(n + 3 >= 256 && n + 3 <= 260), 32'h1);
      chk({31'h0, dout[1]}, 32'h0);
      rchk(cal_sync_pkg::ADDR_ADC_STAT, 32'hF);
      rchk(tbl[m - 4], {8'h00, raw});
    end
    $display("test calibration done");
    summarize();
  end
endmodule // adc_calibration_sync_control_tb
